// *** pkg/dsc_regs.svh ***
// Purpose: named constants for the dual converter link and its controller registers
// Assumes: 32-bit AXI4-Lite data, 100 MHz aclk
// Notes: offsets are byte addresses of aligned words
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
`define DSC_RES_W 14
`define DSC_CNT_W 8
`define DSC_CONV_STEPS 8'h0E
`define DSC_OFF_CTRL 4'h0
`define DSC_OFF_STAT 4'h4
`define DSC_OFF_RES_A 4'h8
`define DSC_OFF_RES_B 4'hC
`define DSC_CTRL_START 0
`define DSC_CTRL_PAIR 1
`define DSC_CTRL_SPAN_LO 2
`define DSC_CTRL_SPAN_HI 3
`define DSC_CTRL_REFERENCE_SOURCE_SELECT 4
`define DSC_STAT_BUSY 0
`define DSC_STAT_DONE 1
`define DSC_STAT_REFOK 2
`define DSC_SPAN_RSVD 2'h3
`define DSC_REF_SETTLE_US 70
`define DSC_CLK_MHZ 100
`define DSC_REF_SETTLE_CYC (`DSC_REF_SETTLE_US * `DSC_CLK_MHZ)
`define DSC_SCLK_HALF 4'hF
`define DSC_RESP_OKAY 2'h0
`define DSC_RESP_SLVERR 2'h2
`endif

// *** pkg/dsc_pkg.sv ***
// Purpose: shared types of the dual converter link
// Assumes: constants come from dsc_regs.svh
// Notes: span codes 0..2 select +-10, +-5, 0..10; 3 is reserved
`include "dsc_regs.svh"
package dsc_pkg;
  typedef logic [`DSC_RES_W-1:0] dsc_result_t;
  typedef enum logic [1:0] {
    DSC_SPAN_PM10 = 2'h0,
    DSC_SPAN_PM5 = 2'h1,
    DSC_SPAN_UNI10 = 2'h2,
    DSC_SPAN_RSVD = 2'h3
  } dsc_span_t;
endpackage

// *** pkg/dsc_link_if.sv ***
// Purpose: pins between the converter device and its host controller
// Assumes: link_clk is the device's own clock port; serial clock is made by the host
// Notes: all pins one-way
interface dsc_link_if;
  logic conversion_start_n;
  logic channel_pair_sel;
  logic input_span_sel0;
  logic input_span_sel1;
  logic reference_source_select;
  logic busy;
  logic serial_clk;
  logic data_out_a;
  logic data_out_b;
  modport device (
    input conversion_start_n, channel_pair_sel, input_span_sel0, input_span_sel1,
    input reference_source_select, serial_clk,
    output busy, data_out_a, data_out_b
  );
  modport host (
    output conversion_start_n, channel_pair_sel, input_span_sel0, input_span_sel1,
    output reference_source_select, serial_clk,
    input busy, data_out_a, data_out_b
  );
endinterface

// *** verilog/dsc_device.sv ***
// Purpose: conversion control of the dual simultaneous-sampling converter
// Assumes: link_clk stands for the internal oscillator and runs free
// Notes: analog samples arrive as digital two's complement codes on user ports
`include "dsc_regs.svh"
module dsc_device
  import dsc_pkg::*;
(
  // oscillator and reset
  input wire logic link_clk,
  input wire logic aresetn,
  // link pins
  dsc_link_if.device link,
  // analog stand-ins, two's complement codes of each input
  input wire dsc_pkg::dsc_result_t sample_a_first,
  input wire dsc_pkg::dsc_result_t sample_a_second,
  input wire dsc_pkg::dsc_result_t sample_b_first,
  input wire dsc_pkg::dsc_result_t sample_b_second,
  // observation
  output logic tracking,
  output dsc_pkg::dsc_span_t span,
  output logic span_reserved
);
  import dsc_pkg::*;

  ////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    DSC_D_TRACK = 3'h1,
    DSC_D_CONV = 3'h2,
    DSC_D_SHIFT = 3'h4
  } dsc_dstate_t;

  typedef struct packed {
    dsc_dstate_t st;
    logic [1:0] rst_sync;
    logic [2:0] start_sync;
    logic [2:0] sclk_sync;
    logic pair_sync1;
    logic pair_sync2;
    logic [1:0] span_sync1;
    logic [1:0] span_sync2;
    logic pair_active;
    logic pair_next;
    logic [`DSC_CNT_W-1:0] steps;
    dsc_result_t held_a;
    dsc_result_t held_b;
    dsc_result_t sar_a;
    dsc_result_t sar_b;
    dsc_result_t shr_a;
    dsc_result_t shr_b;
    logic busy;
    logic tracking;
    dsc_span_t span;
    logic span_reserved;
    logic dout_a;
    logic dout_b;
  } dsc_dev_t;

  dsc_dev_t r;
  dsc_dev_t next_r;

  // offset binary and two's complement differ only in the sign bit
  function automatic dsc_result_t dsc_flip_sign(dsc_result_t v);
    dsc_flip_sign = v ^ {1'b1, {(`DSC_RES_W-1){1'b0}}};
  endfunction

  // one approximation step: keep trial bit if sample (offset binary) is at or above it
  function automatic dsc_result_t sar_step(dsc_result_t acc, dsc_result_t held, logic [`DSC_CNT_W-1:0] k);
    dsc_result_t trial;
    dsc_result_t ob;
    trial = acc | (dsc_result_t'(1) << k);
    ob = dsc_flip_sign(held);
    sar_step = (ob >= trial) ? trial : acc;
  endfunction

  ////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.rst_sync = {r.rst_sync[0], aresetn};
    next_r.start_sync = {r.start_sync[1:0], link.conversion_start_n};
    next_r.sclk_sync = {r.sclk_sync[1:0], link.serial_clk};
    next_r.pair_sync1 = link.channel_pair_sel;
    next_r.pair_sync2 = r.pair_sync1;
    next_r.span_sync1 = {link.input_span_sel1, link.input_span_sel0};
    next_r.span_sync2 = r.span_sync1;
    next_r.span = dsc_span_t'(r.span_sync2);
    next_r.span_reserved = (r.span_sync2 == `DSC_SPAN_RSVD);
    case (r.st)
      DSC_D_TRACK, DSC_D_SHIFT: begin
        // start edge is sampled from sync stages 1 and 2 only
        if (r.start_sync[2] && !r.start_sync[1]) begin
          // both holds freeze together, pair chosen earlier applies now
          next_r.held_a = r.pair_active ? sample_a_second : sample_a_first;
          next_r.held_b = r.pair_active ? sample_b_second : sample_b_first;
          next_r.tracking = 1'b0;
          next_r.sar_a = '0;
          next_r.sar_b = '0;
          next_r.steps = `DSC_CONV_STEPS;
          next_r.busy = 1'b1;
          next_r.pair_next = r.pair_sync2;
          next_r.st = DSC_D_CONV;
        end else if (r.st == DSC_D_SHIFT && r.sclk_sync[2] && !r.sclk_sync[1]) begin
          // host falling edge: present next bit, host samples on rising
          next_r.shr_a = {r.shr_a[`DSC_RES_W-2:0], 1'b0};
          next_r.shr_b = {r.shr_b[`DSC_RES_W-2:0], 1'b0};
          next_r.dout_a = r.shr_a[`DSC_RES_W-1];
          next_r.dout_b = r.shr_b[`DSC_RES_W-1];
        end
      end
      DSC_D_CONV: begin
        // steps run on the oscillator, not the host clock
        if (r.steps != '0) begin
          next_r.sar_a = sar_step(r.sar_a, r.held_a, r.steps - 1'b1);
          next_r.sar_b = sar_step(r.sar_b, r.held_b, r.steps - 1'b1);
          next_r.steps = r.steps - 1'b1;
        end else begin
          // convert back from offset binary to two's complement
          next_r.shr_a = dsc_flip_sign(r.sar_a);
          next_r.shr_b = dsc_flip_sign(r.sar_b);
          next_r.dout_a = ~r.sar_a[`DSC_RES_W-1];
          next_r.dout_b = ~r.sar_b[`DSC_RES_W-1];
          next_r.pair_active = r.pair_next;
          next_r.busy = 1'b0;
          next_r.tracking = 1'b1;
          next_r.st = DSC_D_SHIFT;
        end
      end
      default: next_r.st = DSC_D_TRACK;
    endcase
  end

  ////////////////////////////////////////////////////////////
  always_ff @(posedge link_clk) begin
    // reset comes from the bus clock side and is retimed before use
    if (!r.rst_sync[1]) begin
      r <= '0;
      r.rst_sync <= {r.rst_sync[0], aresetn};
      r.st <= DSC_D_TRACK;
      r.start_sync <= 3'h7;
      r.sclk_sync <= 3'h7;
      r.pair_active <= 1'b0;
      r.pair_next <= 1'b0;
      r.tracking <= 1'b1;
      r.span <= DSC_SPAN_PM10;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////
  assign link.busy = r.busy;
  assign link.data_out_a = r.dout_a;
  assign link.data_out_b = r.dout_b;
  assign tracking = r.tracking;
  assign span = r.span;
  assign span_reserved = r.span_reserved;
endmodule

// *** verilog/dsc_host.sv ***
// Purpose: host controller driving conversions and serial reads, with AXI4-Lite registers
// Assumes: aclk 100 MHz; device pins pass two flops before use
// Notes: serial clock made by dividing aclk
//
// The AXI4-Lite slave port and the address map were decided locally.
`include "dsc_regs.svh"
// Behaviour
// - start falling edge holds and starts both
// - busy high throughout both conversions
// - busy low when both conversions done
// - busy falling edge returns to tracking
// - approximation steps clocked by internal oscillator
// - host reads results only after conversion
// - two data outputs share serial clock
// - host holds reference select defined level
// - two span pins choose three spans
// - host keeps span stable in acquisition; span pins follow every control register write with wstrb[0] set, at any time
// - pair select latched at busy rising
// - pair select defaults to first inputs
// - pair 0 first inputs, 1 second
// - results coded in two's complement
// - code steps one LSB of span
// - 16384 codes, 14-bit result width
// - track after busy low, hold at start
// - internal reference needs 70 us settling
module dsc_host
  import dsc_pkg::*;
#(
  parameter int unsigned REF_SETTLE_CYC = `DSC_REF_SETTLE_CYC
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link pins
  dsc_link_if.host link
);
  import dsc_pkg::*;

  ////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    DSC_H_IDLE = 4'h1,
    DSC_H_WAIT_HI = 4'h2,
    DSC_H_WAIT_LO = 4'h4,
    DSC_H_READ = 4'h8
  } dsc_hstate_t;

  typedef struct packed {
    dsc_hstate_t st;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0] ctrl;
    logic done;
    logic [31:0] settle;
    logic [1:0] busy_sync;
    logic [1:0] da_sync;
    logic [1:0] db_sync;
    logic conversion_start_n_n;
    logic sclk;
    logic [3:0] div;
    logic [4:0] bits;
    dsc_result_t res_a;
    dsc_result_t res_b;
  } dsc_host_t;

  dsc_host_t r;
  dsc_host_t next_r;

  function automatic logic dsc_ref_ok(dsc_host_t s);
    dsc_ref_ok = (s.settle == '0);
  endfunction

  function automatic logic [31:0] dsc_sext(dsc_result_t v);
    dsc_sext = {{(32-`DSC_RES_W){v[`DSC_RES_W-1]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.busy_sync = {r.busy_sync[0], link.busy};
    next_r.da_sync = {r.da_sync[0], link.data_out_a};
    next_r.db_sync = {r.db_sync[0], link.data_out_b};
    if (r.settle != '0) next_r.settle = r.settle - 32'h1;
    // write channel
    if (s_axi_awvalid && !r.aw_got && !r.bvalid) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_got && !r.bvalid) begin
      next_r.w_got = 1'b1;
      next_r.w_data = s_axi_wdata;
    end
    if (r.aw_got && r.w_got) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = `DSC_RESP_OKAY;
      if (r.aw_addr == `DSC_OFF_CTRL) begin
        if (s_axi_wstrb[0]) next_r.ctrl = r.w_data[4:0];
      end else next_r.bresp = `DSC_RESP_SLVERR;
    end
    if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
    // read channel
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `DSC_RESP_OKAY;
      case (s_axi_araddr)
        `DSC_OFF_CTRL: next_r.rdata = {27'h0, r.ctrl};
        `DSC_OFF_STAT: next_r.rdata = {29'h0, dsc_ref_ok(r), r.done, r.st != DSC_H_IDLE};
        `DSC_OFF_RES_A: next_r.rdata = dsc_sext(r.res_a);
        `DSC_OFF_RES_B: next_r.rdata = dsc_sext(r.res_b);
        default: begin
          next_r.rdata = 32'h0;
          next_r.rresp = `DSC_RESP_SLVERR;
        end
      endcase
    end
    if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;
    // conversion sequencer
    case (r.st)
      DSC_H_IDLE: begin
        // with the internal reference chosen, starts wait until it has settled
        if (r.ctrl[`DSC_CTRL_START] && (dsc_ref_ok(r) || !r.ctrl[`DSC_CTRL_REFERENCE_SOURCE_SELECT])) begin
          next_r.ctrl[`DSC_CTRL_START] = 1'b0;
          next_r.done = 1'b0;
          next_r.conversion_start_n_n = 1'b0;
          next_r.st = DSC_H_WAIT_HI;
        end
      end
      DSC_H_WAIT_HI: if (r.busy_sync[1]) begin
        next_r.conversion_start_n_n = 1'b1;
        next_r.st = DSC_H_WAIT_LO;
      end
      DSC_H_WAIT_LO: if (!r.busy_sync[1]) begin
        next_r.bits = 5'h0;
        next_r.div = 4'h0;
        next_r.st = DSC_H_READ;
      end
      DSC_H_READ: begin
        next_r.div = r.div + 4'h1;
        if (r.div == `DSC_SCLK_HALF) begin
          next_r.div = 4'h0;
          next_r.sclk = ~r.sclk;
          if (!r.sclk) begin
            // rising edge: sample both lines
            next_r.res_a = {r.res_a[`DSC_RES_W-2:0], r.da_sync[1]};
            next_r.res_b = {r.res_b[`DSC_RES_W-2:0], r.db_sync[1]};
            next_r.bits = r.bits + 5'h1;
          end else if (r.bits == 5'(`DSC_RES_W)) begin
            // clock parks high: no extra shift edge at the device
            next_r.sclk = 1'b1;
            next_r.done = 1'b1;
            next_r.st = DSC_H_IDLE;
          end
        end
      end
      default: next_r.st = DSC_H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= DSC_H_IDLE;
      r.conversion_start_n_n <= 1'b1;
      r.sclk <= 1'b1;
      r.ctrl <= 5'h10;
      r.settle <= REF_SETTLE_CYC;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign link.conversion_start_n = r.conversion_start_n_n;
  assign link.serial_clk = r.sclk;
  assign link.channel_pair_sel = r.ctrl[`DSC_CTRL_PAIR];
  assign link.input_span_sel0 = r.ctrl[`DSC_CTRL_SPAN_LO];
  assign link.input_span_sel1 = r.ctrl[`DSC_CTRL_SPAN_HI];
  assign link.reference_source_select = r.ctrl[`DSC_CTRL_REFERENCE_SOURCE_SELECT];
endmodule

// *** bench/dsc_link_asserts.sv ***
// Purpose: concurrent checks on the converter link pins
// Assumes: link_clk clocks the device, aclk the host and its serial clock
// Notes: one shared synchronous active-low reset
module dsc_link_asserts (
  // clocks and reset
  input wire logic link_clk,
  input wire logic aclk,
  input wire logic aresetn,
  // link pins
  input wire logic conversion_start_n,
  input wire logic channel_pair_sel,
  input wire logic input_span_sel0,
  input wire logic input_span_sel1,
  input wire logic reference_source_select,
  input wire logic busy,
  input wire logic serial_clk,
  input wire logic data_out_a,
  input wire logic data_out_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] busy_cnt;
  logic [4:0] sclk_cnt;
  ////////////////////////////////////////////////////////////
  // busy length in oscillator cycles, serial clock rises per read
  always_ff @(posedge link_clk) begin
    if (!aresetn) busy_cnt <= 5'h00;
    else busy_cnt <= busy ? busy_cnt + 5'h01 : 5'h00;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || busy) sclk_cnt <= 5'h00;
    else if ($rose(serial_clk)) sclk_cnt <= sclk_cnt + 5'h01;
  end
  ////////////////////////////////////////////////////////////
  a_start_busy: assert property (@(posedge link_clk) disable iff (!aresetn)
    $fell(conversion_start_n) && !busy |-> ##[1:5] busy) else $error("busy did not follow start");
  a_busy_length: assert property (@(posedge link_clk) disable iff (!aresetn)
    $fell(busy) |-> busy_cnt == 5'h0F) else $error("busy length wrong");
  a_start_held: assert property (@(posedge link_clk) disable iff (!aresetn)
    $fell(conversion_start_n) |-> !conversion_start_n [*3]) else $error("start released early");
  a_data_frozen: assert property (@(posedge link_clk) disable iff (!aresetn)
    busy && $past(busy) |-> $stable(data_out_a) && $stable(data_out_b)) else $error("data moved in conversion");
  a_span_steady: assert property (@(posedge link_clk) disable iff (!aresetn)
    busy |-> $stable({input_span_sel1, input_span_sel0, reference_source_select})) else $error("span changed");
  a_reset_idle: assert property (@(posedge link_clk) disable iff (!aresetn)
    $rose(aresetn) |-> conversion_start_n && serial_clk && !busy) else $error("link not idle after reset");
  a_sclk_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    busy |-> serial_clk) else $error("serial clock during conversion");
  a_sclk_count: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(serial_clk) |-> sclk_cnt < 5'h0E) else $error("too many serial clocks");
  c_conv_done: cover property (@(posedge link_clk) disable iff (!aresetn) $fell(busy));
  c_read_full: cover property (@(posedge aclk) disable iff (!aresetn) $rose(serial_clk) && sclk_cnt == 5'h0D);
  c_pair_two: cover property (@(posedge link_clk) disable iff (!aresetn) $rose(busy) && channel_pair_sel);
endmodule

// *** bench/dual_sar_conversion_control_test.sv ***
// Purpose: drives the host over AXI4-Lite and checks both link ends
// Assumes: reference settle shortened to 20 cycles
// Notes: a result uses the pair latched one conversion earlier
`include "dsc_regs.svh"
module dual_sar_conversion_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dsc_pkg::*;
  logic aclk = '0, link_clk = '0, aresetn = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tracking, span_reserved;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  dsc_span_t span;
  dsc_result_t smp [4] = '{14'h2005, 14'h1FFA, 14'h3FFF, 14'h0123};
  int failures = 0, tests_run = 0, cyc = 0;
  ////////////////////////////////////////////////////////////
  initial forever #5 aclk = ~aclk;
  initial begin
    #3.7;
    forever #16 link_clk = ~link_clk;
  end
  dsc_link_if link ();
  dsc_host #(.REF_SETTLE_CYC(20)) dsc_host_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link);
  dsc_device dsc_device_i (.link_clk, .aresetn, .link, .sample_a_first(smp[0]), .sample_a_second(smp[1]),
    .sample_b_first(smp[2]), .sample_b_second(smp[3]), .tracking, .span, .span_reserved);
  dsc_link_asserts dsc_link_asserts_i (.link_clk, .aclk, .aresetn, .conversion_start_n(link.conversion_start_n),
    .channel_pair_sel(link.channel_pair_sel), .input_span_sel0(link.input_span_sel0),
    .input_span_sel1(link.input_span_sel1), .reference_source_select(link.reference_source_select),
    .busy(link.busy), .serial_clk(link.serial_clk), .data_out_a(link.data_out_a), .data_out_b(link.data_out_b));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (link.busy !== lvl && n < 400) begin
      @(posedge aclk);
      n++;
    end
  endtask
  function automatic logic [31:0] sx(input logic [13:0] s);
    return {{18{s[13]}}, s};
  endfunction
  ////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    logic [31:0] d, c;
    logic p;
    int n;
    p = 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(`DSC_OFF_CTRL, d);
    chk("ctrl reset", 32'h10, d);
    axi_rd(`DSC_OFF_STAT, d);
    chk("ref settling", 32'h0, d & 32'h4);
    axi_wr(`DSC_OFF_STAT, 32'h1, `DSC_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      c = {27'h0, i[0], i[1:0], (i != 1), 1'h0};
      axi_wr(`DSC_OFF_CTRL, c, `DSC_RESP_OKAY);
      n = 0;
      while (span !== dsc_span_t'(i[1:0]) && n < 40) begin
        @(posedge aclk);
        n++;
      end
      chk("span", i, {30'h0, span});
      chk("span reserved", 32'(i == 3), {31'h0, span_reserved});
      if (i < 3) begin
        axi_wr(`DSC_OFF_CTRL, c | 32'h1, `DSC_RESP_OKAY);
        wait_busy(1'h1);
        chk("tracking in hold", 32'h0, {31'h0, tracking});
        axi_rd(`DSC_OFF_STAT, d);
        chk("status busy", 32'h1, d & 32'h3);
        wait_busy(1'h0);
        n = 0;
        do begin
          axi_rd(`DSC_OFF_STAT, d);
          n++;
        end while (d[1] !== 1'h1 && n < 250);
        chk("status done", 32'h6, d & 32'h7);
        chk("tracking after", 32'h1, {31'h0, tracking});
        axi_rd(`DSC_OFF_RES_A, d);
        chk("result a", sx(smp[p]), d);
        axi_rd(`DSC_OFF_RES_B, d);
        chk("result b", sx(smp[2 + p]), d);
        p = (i != 1);
        smp[0] <= smp[0] - 14'h0011;
        smp[3] <= smp[3] + 14'h0101;
      end
    end
    report_and_stop();
  end
endmodule
